// file: svf_defs.svh
`ifndef SVF_DEFS_SVH
`define SVF_DEFS_SVH

// Synchroniser depth for pin inputs
`define SVF_SYNC_STAGES  2
// Width of the interval and width counters
`define SVF_CNT_W        16
// Conversion clock periods in one reset pulse
`define SVF_RST_PERIODS  16'h0001
// Shortest output interval (one reset plus one integrate period)
`define SVF_DIV_FULL     16'h0002
// Consecutive full-scale intervals before overrange is flagged
`define SVF_OVR_RUN      4'h4
`define SVF_OVR_W        4
// Reset values
`define SVF_CNT_RST      16'h0000
`define SVF_OVR_RST      4'h0

`endif

// file: svf_pkg.sv
package svf_pkg;

    // Phase of the conversion loop, Gray coded except the RESET to INTEG and IDLE to ARMED steps
    typedef enum logic [1:0] {
        SVF_IDLE  = 2'b00,
        SVF_INTEG = 2'b01,
        SVF_ARMED = 2'b11,
        SVF_RESET = 2'b10
    } svf_phase_e;

endpackage : svf_pkg

// file: svf_sync_if.sv
interface svf_sync_if;
    logic clk_lvl;
    logic clk_rise;
    logic clk_fall;
    logic comp_lvl;

    modport prod (
        output clk_lvl,
        output clk_rise,
        output clk_fall,
        output comp_lvl
    );

    modport cons (
        input clk_lvl,
        input clk_rise,
        input clk_fall,
        input comp_lvl
    );
endinterface : svf_sync_if

// file: svf_sync.sv
`include "svf_defs.svh"

module svf_sync #(
    parameter int STAGES = `SVF_SYNC_STAGES
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // Raw pins
    input  wire logic  conv_clk_pin,
    input  wire logic  comp_pin,
    // Synchronised view
    svf_sync_if.prod   sif
);

    logic [1:0]        raw;
    logic [STAGES-1:0] chain_q [2];
    logic              clk_prev_q;

    assign raw = {comp_pin, conv_clk_pin};

    function automatic logic edge_of(input logic now, input logic was, input logic up);
        edge_of = up ? (now & ~was) : (~now & was);
    endfunction : edge_of

    // Only the last stage is ever looked at
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (rst) begin
                    chain_q[g] <= '0;
                end else begin
                    chain_q[g] <= {chain_q[g][STAGES-2:0], raw[g]};
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= chain_q[0][STAGES-1];
        end
    end

    assign sif.clk_lvl  = chain_q[0][STAGES-1];
    assign sif.comp_lvl = chain_q[1][STAGES-1];
    assign sif.clk_rise = edge_of(chain_q[0][STAGES-1], clk_prev_q, 1'b1);
    assign sif.clk_fall = edge_of(chain_q[0][STAGES-1], clk_prev_q, 1'b0);

endmodule : svf_sync

// file: svf_top.sv
// Summary of operation
// - Gate passes comparator while latch low, forces low while latch high.
// - Flip-flop samples gate only on falling conversion clock edge.
// - Latch holds while clock low, follows flip-flop while clock high.
// - Clock high after captured crossing raises latch: integrator reset, gate blocked.
// - Next falling edge captures low; next high level drops latch, reopening gate.
// - Every reset pulse lasts exactly one conversion clock period.
// - Interval between output pulses is a whole number of clock periods.
// - Quarter-reference input gives one pulse every four clocks.
// - Early crossing shortens integrate phase to two, an occasional divide-by-three.
// - Full-scale rate is half the conversion clock.
// - Comparator held high settles into a steady divide-by-two.
`include "svf_defs.svh"

module svf_top #(
    parameter int CNT_W = `SVF_CNT_W
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // Pins from the analog side and the conversion clock
    input  wire logic               conv_clk_pin,
    input  wire logic               comp_pin,
    // Integrator switch and frequency output
    output logic                    integ_reset,
    output logic                    pulse_rate_output,
    output logic                    pulse_strobe,
    // Status
    output svf_pkg::svf_phase_e     phase,
    output logic [CNT_W-1:0]        last_interval,
    output logic                    interval_valid,
    output logic [CNT_W-1:0]        last_reset_width,
    output logic                    full_scale,
    output logic                    overrange
);

    svf_sync_if sif ();

    svf_sync #(
        .STAGES       (`SVF_SYNC_STAGES)
    ) u_sync (
        .mclk         (mclk),
        .rst          (rst),
        .conv_clk_pin (conv_clk_pin),
        .comp_pin     (comp_pin),
        .sif          (sif)
    );

    logic                   gate;
    logic                   flop_q;
    logic                   latch_q;
    logic                   latch_d;
    logic                   latch_up;
    logic                   latch_dn;
    logic                   strobe_q;
    logic                   seen_q;
    logic                   valid_q;
    logic [CNT_W-1:0]       gap_cnt_q;
    logic [CNT_W-1:0]       gap_cnt_d;
    logic [CNT_W-1:0]       interval_d;
    logic [CNT_W-1:0]       wid_cnt_q;
    logic [CNT_W-1:0]       interval_q;
    logic [CNT_W-1:0]       width_q;
    logic [`SVF_OVR_W-1:0]  run_q;
    svf_pkg::svf_phase_e    phase_q;

    // Combinational gate: the only loop back from latch to comparator path
    assign gate = sif.comp_lvl & ~latch_q;

    // Crossing is ignored until the falling edge, which blocks glitches
    always_ff @(posedge mclk) begin
        if (rst) begin
            flop_q <= 1'b0;
        end else if (sif.clk_fall) begin
            flop_q <= gate;
        end
    end

    // Transparent only while the clock is high
    always_comb begin
        latch_d = latch_q;
        if (sif.clk_lvl) begin
            latch_d = flop_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
        end
    end

    assign latch_up = ~latch_q & latch_d;
    assign latch_dn = latch_q & ~latch_d;

    // Output level is the latch itself, so each pulse is one reset
    assign integ_reset       = latch_q;
    assign pulse_rate_output = latch_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= latch_up;
        end
    end

    assign pulse_strobe = strobe_q;

    // Conversion clock rises since the previous output pulse
    always_comb begin
        gap_cnt_d = gap_cnt_q;
        if (latch_up) begin
            gap_cnt_d = `SVF_CNT_RST;
        end else if (sif.clk_rise && gap_cnt_q != {CNT_W{1'b1}}) begin
            gap_cnt_d = gap_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gap_cnt_q <= `SVF_CNT_RST;
        end else begin
            gap_cnt_q <= gap_cnt_d;
        end
    end

    // Latch only moves on a rise, so the interval is whole periods
    assign interval_d = gap_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

    always_ff @(posedge mclk) begin
        if (rst) begin
            interval_q <= `SVF_CNT_RST;
            valid_q    <= 1'b0;
            seen_q     <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (latch_up) begin
                seen_q <= 1'b1;
                // First pulse after reset has no predecessor to measure from
                if (seen_q) begin
                    interval_q <= interval_d;
                    valid_q    <= 1'b1;
                end
            end
        end
    end

    assign last_interval  = interval_q;
    assign interval_valid = valid_q;

    // Reset width in conversion periods, expected to be one
    always_ff @(posedge mclk) begin
        if (rst) begin
            wid_cnt_q <= `SVF_CNT_RST;
            width_q   <= `SVF_CNT_RST;
        end else begin
            if (latch_up) begin
                wid_cnt_q <= `SVF_CNT_RST;
            end else if (latch_dn) begin
                width_q <= wid_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (latch_q && sif.clk_rise) begin
                wid_cnt_q <= wid_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign last_reset_width = width_q;

    // Divide-by-two run length; moves with the interval so the flag never lags it
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_q <= `SVF_OVR_RST;
        end else if (latch_up && seen_q) begin
            if (interval_d != `SVF_DIV_FULL) begin
                run_q <= `SVF_OVR_RST;
            end else if (run_q != `SVF_OVR_RUN) begin
                run_q <= run_q + {{(`SVF_OVR_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign full_scale = seen_q && interval_q == `SVF_DIV_FULL;
    assign overrange  = run_q == `SVF_OVR_RUN;

    // Loop phase for observation only
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_q <= svf_pkg::SVF_IDLE;
        end else begin
            case (phase_q)
                svf_pkg::SVF_IDLE: begin
                    // A crossing may already stand at the first fall
                    if (sif.clk_fall && gate) begin
                        phase_q <= svf_pkg::SVF_ARMED;
                    end else if (sif.clk_fall) begin
                        phase_q <= svf_pkg::SVF_INTEG;
                    end
                end
                svf_pkg::SVF_INTEG: begin
                    if (sif.clk_fall && gate) begin
                        phase_q <= svf_pkg::SVF_ARMED;
                    end
                end
                svf_pkg::SVF_ARMED: begin
                    if (latch_up) begin
                        phase_q <= svf_pkg::SVF_RESET;
                    end
                end
                svf_pkg::SVF_RESET: begin
                    if (latch_dn) begin
                        phase_q <= svf_pkg::SVF_INTEG;
                    end
                end
                default: begin
                    phase_q <= svf_pkg::SVF_IDLE;
                end
            endcase
        end
    end

    assign phase = phase_q;

endmodule : svf_top

// file: svf_analog.sv
module svf_analog (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Input level and switch
    input  wire logic [7:0] lvl,
    input  wire logic       integ_reset,
    // Pins
    output logic            conv_clk_pin,
    output logic            comp_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        [1:0]  div_q;
    logic signed [15:0] acc_q;
    // Clock parked low in reset, so no false edge follows release
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_q        <= 2'h0;
            conv_clk_pin <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            conv_clk_pin <= conv_clk_pin ^ (div_q == 2'h3);
        end
    end
    // Reference is 64 per mclk, so level 16 is the quarter point
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_q <= 16'sh0000;
        end else begin
            acc_q <= acc_q + $signed({8'h00, lvl}) - (integ_reset ? 16'sh0040 : 16'sh0000);
        end
    end
    assign comp_pin = (acc_q > 16'sh0000);
endmodule : svf_analog

// file: svf_top_checker.sv
module svf_top_checker #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic                mclk,
    input wire logic                rst,
    // Pins
    input wire logic                conv_clk_pin,
    input wire logic                comp_pin,
    // Outputs
    input wire logic                integ_reset,
    input wire logic                pulse_rate_output,
    input wire logic                pulse_strobe,
    input wire svf_pkg::svf_phase_e phase,
    input wire logic [CNT_W-1:0]    last_interval,
    input wire logic                interval_valid,
    input wire logic [CNT_W-1:0]    last_reset_width,
    input wire logic                full_scale,
    input wire logic                overrange
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] gap_q;
    logic [4:0] low_q;
    logic       seen_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Modulo the 8 mclk conversion period the bench uses
    always_ff @(posedge mclk) begin
        gap_q <= $rose(integ_reset) ? 3'h1 : gap_q + 3'h1;
    end
    always_ff @(posedge mclk) begin
        seen_q <= !rst && (seen_q || $rose(integ_reset));
    end
    always_ff @(posedge mclk) begin
        low_q <= (rst || comp_pin) ? 5'h00 : low_q + {4'h0, low_q != 5'h1f};
    end
    a_out_is_reset: assert property (pulse_rate_output == integ_reset)
        else $error("output differs from reset switch");
    a_strobe_after_rise: assert property ($rose(pulse_rate_output) |-> pulse_strobe ##1 !pulse_strobe)
        else $error("strobe misplaced");
    a_width_one_period: assert property ($rose(integ_reset) |-> integ_reset[*8] ##1 !integ_reset)
        else $error("reset pulse not one period");
    a_gap_whole_periods: assert property ($rose(integ_reset) && seen_q |-> gap_q == 3'h0)
        else $error("interval not whole periods");
    a_interval_min_two: assert property (interval_valid |-> last_interval >= CNT_W'(2))
        else $error("interval below two");
    a_width_report: assert property (interval_valid |-> last_reset_width == CNT_W'(1))
        else $error("reset width not one");
    a_full_scale_two: assert property ((full_scale |-> last_interval == CNT_W'(2)) and ($changed(full_scale) |-> interval_valid))
        else $error("full scale without interval two");
    a_phase_follows: assert property (integ_reset == (phase == svf_pkg::SVF_RESET))
        else $error("phase does not follow reset switch");
    a_overrange_full: assert property (overrange |-> full_scale)
        else $error("overrange without full scale");
    a_needs_crossing: assert property ($rose(integ_reset) |-> low_q < 5'h14)
        else $error("reset without crossing");
    c_overrange: cover property ($rose(overrange));
    c_div_three: cover property (interval_valid && last_interval == CNT_W'(3));
    c_div_four: cover property (interval_valid && last_interval == CNT_W'(4));
endmodule : svf_top_checker
bind svf_top svf_top_checker #(.CNT_W(CNT_W)) u_svf_top_checker (.mclk, .rst, .conv_clk_pin,
    .comp_pin, .integ_reset, .pulse_rate_output, .pulse_strobe, .phase, .last_interval,
    .interval_valid, .last_reset_width, .full_scale, .overrange);

// file: svf_top_tb.sv
module svf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                mclk = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          lvl = 8'h00;
    logic [15:0]         lfsr_q = 16'h0a27;
    logic                conv_clk_pin, comp_pin, integ_reset, pulse_rate_output;
    logic                pulse_strobe, interval_valid, full_scale, overrange;
    svf_pkg::svf_phase_e phase;
    logic [15:0]         last_interval, last_reset_width, imin, imax;
    int                  err_total = 0;
    int                  comparisons = 0;
    int                  cnt, ovr, fs;
    initial forever #2 mclk = ~mclk;
    svf_top u_svf_top (.mclk, .rst, .conv_clk_pin, .comp_pin, .integ_reset, .pulse_rate_output,
        .pulse_strobe, .phase, .last_interval, .interval_valid, .last_reset_width,
        .full_scale, .overrange);
    svf_analog u_svf_analog (.mclk, .rst, .lvl, .integ_reset, .conv_clk_pin, .comp_pin);
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // Pulses in a 64-period gate: level per period over one reset charge
    function automatic int exp_cnt(input logic [7:0] l);
        return (l > 8'h20) ? 32 : int'(l);
    endfunction : exp_cnt
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check
    task automatic run(input logic [7:0] l);
        int cyc;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        lvl <= l;
        cnt = 0;
        ovr = 0;
        fs = 0;
        imin = 16'hffff;
        imax = 16'h0000;
        for (cyc = 0; cyc < 1024; cyc++) begin
            @(posedge mclk);
            #1;
            cnt += (cyc >= 256 && cyc < 768 && pulse_strobe === 1'b1);
            ovr |= (overrange === 1'b1);
            fs |= (cyc >= 128 && full_scale === 1'b1);
            if (cyc >= 128 && interval_valid === 1'b1) begin
                imin = (last_interval < imin) ? last_interval : imin;
                imax = (last_interval > imax) ? last_interval : imax;
            end
        end
        $display("level %0d done, %0d pulses", l, cnt);
        check(cnt >= exp_cnt(l) - 1 && cnt <= exp_cnt(l) + 1, "pulse count");
        if (l != 8'h00 && cnt == 0) begin
            err_total++;
            finish_test();
        end
    endtask : run
    initial begin
        run(8'h00);
        check(cnt == 0 && imax === 16'h0000, "pulses without input");
        run(8'h10);
        check(imin === 16'h0004 && imax === 16'h0004 && fs == 0, "quarter divide");
        run(8'h11);
        check(imin === 16'h0003 && imax === 16'h0004, "lost cycle");
        run(8'h28);
        check(imin === 16'h0002 && imax === 16'h0002 && ovr == 1 && fs == 1, "overrange");
        repeat (6) begin
            lfsr_q = lfsr_next(lfsr_q);
            run({2'b00, lfsr_q[5:0]});
            check(imax === 16'h0000 || imin >= 16'h0002, "interval too short");
        end
        finish_test();
    end
endmodule : svf_top_tb
